// >>> rtl/ics_pkg.sv
// Constants, carriers and state layout for the client flag and status block
package ics_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h04;
    localparam logic [7:0] IDX_ENCLR = 8'h14;
    localparam logic [7:0] IDX_ENSET = 8'h16;
    localparam logic [7:0] IDX_FLAGS = 8'h18;
    localparam logic [7:0] IDX_STATUS = 8'h1a;
    localparam logic [7:0] IDX_DATA = 8'h28;

    // Flag and enable bit positions
    localparam int FLG_STOP_RECEIVED_FLAG = 0;
    localparam int FLG_ADDRESS_MATCH_FLAG = 1;
    localparam int FLG_DATA_READY_FLAG = 2;
    localparam int FLG_ERROR = 7;
    localparam logic [7:0] FLG_MASK = 8'h87;

    // Status bit positions
    localparam int ST_BUS_FAULT_FLAG = 0;
    localparam int ST_TRANSMIT_CLASH_FLAG = 1;
    localparam int ST_RECEIVED_NOT_ACK = 2;
    localparam int ST_DIR = 3;
    localparam int ST_SR = 4;
    localparam int ST_LOWT = 6;
    localparam int ST_HOLD = 7;
    localparam int ST_SEXT = 9;
    localparam int ST_HS = 10;
    localparam logic [15:0] ST_W1C_MASK = 16'h0643;

    // Control register fields
    localparam int CB_SMART_MODE_ENABLE = 8;
    localparam int CB_GROUP_COMMAND_ENABLE = 9;
    localparam int CB_CMD = 16;
    localparam int CB_ACKNOWLEDGE_ACTION = 18;

    // Reset values
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] STATUS_RST = 16'h0000;

    // Command codes
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_FINISH = 2'h2;
    localparam logic [1:0] CMD_ACK = 2'h3;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One-hot register select positions
    localparam int SEL_CTRL = 0;
    localparam int SEL_ENCLR = 1;
    localparam int SEL_ENSET = 2;
    localparam int SEL_FLAGS = 3;
    localparam int SEL_STATUS = 4;
    localparam int SEL_DATA = 5;
    typedef logic [5:0] ics_sel_t;

    // Events from the shift engine, same clock
    typedef struct packed {
        logic byte_done;      // Byte sent or received cleanly
        logic addr_match;     // Valid own address received
        logic addr_dir;       // Direction of that address, 1 = host read
        logic addr_rep_start; // That address followed a repeated start
        logic host_nack;      // Host answer to last byte sent
        logic hs_code;        // Start followed by host code
        logic ext_tout;       // Extend time-out
        logic low_tout;       // Clock low time-out
        logic tx_clash;       // Could not drive a high bit
        logic bus_fault;      // Illegal condition seen by engine
        logic [7:0] rx_byte;  // Last received byte
    } ics_evt_s;

    // All block state
    typedef struct packed {
        logic aw_v;
        logic [7:0] aw_addr;
        logic w_v;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic b_v;
        logic [1:0] b_resp;
        logic r_v;
        logic [31:0] r_data;
        logic [1:0] r_resp;
        logic [7:0] en;
        logic [7:0] flg;
        logic [15:0] st;
        logic ack_action;
        logic smart_mode_enable;
        logic group_command_enable;
        logic ack_go;
        logic ack_nack;
        logic cmd_go;
        logic [1:0] cmd_code;
        logic [7:0] tx_byte;
        logic txn;
        logic grp;
        logic released;
        logic start_seen;
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
    } ics_state_s;

endpackage

// >>> rtl/ics_top.sv
// Flag, enable and status registers of the two-wire client, AXI4-Lite slave
`timescale 1ns/1ps
module ics_top (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Bus pins, asynchronous to aclk
    input wire logic scl_in,
    input wire logic sda_in,
    // Shift engine side
    input wire ics_pkg::ics_evt_s evt,
    output logic scl_hold_oe,
    output logic lines_released,
    output logic ack_go,
    output logic ack_nack,
    output logic cmd_go,
    output logic [1:0] cmd_code,
    output logic [7:0] tx_data,
    output logic irq
);
    import ics_pkg::*;

    // Address decode to one-hot select; used by reads and writes
    function automatic ics_sel_t ics_decode(input logic [7:0] addr);
        ics_sel_t s;
        s = '0;
        s[SEL_CTRL] = (addr == {IDX_CTRL[5:0], 2'b00});
        s[SEL_ENCLR] = (addr == {IDX_ENCLR[5:0], 2'b00});
        s[SEL_ENSET] = (addr == {IDX_ENSET[5:0], 2'b00});
        s[SEL_FLAGS] = (addr == {IDX_FLAGS[5:0], 2'b00});
        s[SEL_STATUS] = (addr == {IDX_STATUS[5:0], 2'b00});
        s[SEL_DATA] = (addr == {IDX_DATA[5:0], 2'b00});
        return s;
    endfunction

    ics_state_s q_r; // Registered state
    ics_state_s q_nxt; // Next state

    // Bus handshake terms
    logic do_wr; // Both write halves held, response slot free
    logic rd_take; // Read address taken this cycle
    ics_sel_t wsel; // Write target
    ics_sel_t rsel; // Read target
    logic [31:0] wmask; // Byte strobes widened to bits
    logic [31:0] wd; // Write data after strobes

    // Pin conditions from the synchronised copies only
    logic start_c; // Data falls while clock high
    logic stop_c; // Data rises while clock high
    logic scl_fall; // Clock falling edge

    // Register side effects
    logic cmd_wr; // Non-zero command written
    logic cmd_valid; // Command 2 or 3
    logic cmd3; // Acknowledge command
    logic data_wr; // Data register written
    logic smart_rd; // Data read with smart mode on
    logic [7:0] flg_w1c; // Flag bits written with one
    logic [15:0] st_w1c; // Status bits written with one
    logic address_match_flag_sw_clr; // Software cleared a set match flag
    logic address_match_flag_clr; // Match flag leaves, by any path
    logic auto_clr; // Time-out, fault and clash auto clear
    logic stop_ours; // Stop that sets the stop flag
    logic bad_stop; // Stop right after start, no clock
    logic [15:0] st_set; // Status set pulses
    logic [15:0] st_clr; // Status clear pulses
    logic [7:0] flg_set; // Flag set pulses
    logic [7:0] flg_clr; // Flag clear pulses

    assign do_wr = q_r.aw_v && q_r.w_v && !q_r.b_v;
    assign rd_take = s_axi_arvalid && !q_r.r_v;
    assign wsel = ics_decode(q_r.aw_addr);
    assign rsel = ics_decode(s_axi_araddr);
    assign wmask = {{8{q_r.w_strb[3]}}, {8{q_r.w_strb[2]}},
                    {8{q_r.w_strb[1]}}, {8{q_r.w_strb[0]}}};
    assign wd = q_r.w_data & wmask;

    assign start_c = q_r.scl_s2 && q_r.scl_d && q_r.sda_d && !q_r.sda_s2;
    assign stop_c = q_r.scl_s2 && q_r.scl_d && !q_r.sda_d && q_r.sda_s2;
    assign scl_fall = q_r.scl_d && !q_r.scl_s2;

    // Command strobes; reads of the field always give zero
    assign cmd_wr = do_wr && wsel[SEL_CTRL] &&
                    (wd[CB_CMD+1:CB_CMD] != CMD_NONE);
    assign cmd_valid = cmd_wr && wd[CB_CMD+1];
    assign cmd3 = cmd_wr && (wd[CB_CMD+1:CB_CMD] == CMD_ACK);
    assign data_wr = do_wr && wsel[SEL_DATA] && q_r.w_strb[0];
    assign smart_rd = rd_take && rsel[SEL_DATA] && q_r.smart_mode_enable;
    assign flg_w1c = (do_wr && wsel[SEL_FLAGS]) ? (wd[7:0] & FLG_MASK)
                                                : 8'h00;
    assign st_w1c = (do_wr && wsel[SEL_STATUS]) ? (wd[15:0] & ST_W1C_MASK)
                                                : 16'h0000;
    assign address_match_flag_sw_clr = flg_w1c[FLG_ADDRESS_MATCH_FLAG] && q_r.flg[FLG_ADDRESS_MATCH_FLAG];
    assign address_match_flag_clr = q_r.flg[FLG_ADDRESS_MATCH_FLAG] && (flg_w1c[FLG_ADDRESS_MATCH_FLAG] || cmd_wr);
    assign auto_clr = cmd3 || address_match_flag_clr;
    // Our transaction, or any addressed one under group command
    assign stop_ours = stop_c && (q_r.txn || (q_r.group_command_enable && q_r.grp));
    assign bad_stop = stop_c && q_r.start_seen;

    // Status set pulses from engine and pins
    always_comb begin
        st_set = 16'h0000;
        st_set[ST_SEXT] = evt.ext_tout;
        st_set[ST_LOWT] = evt.low_tout;
        st_set[ST_TRANSMIT_CLASH_FLAG] = evt.tx_clash;
        st_set[ST_BUS_FAULT_FLAG] = evt.bus_fault || bad_stop;
        st_set[ST_HS] = evt.hs_code;
    end

    // Status clear pulses: write of one, stop, or auto clear
    always_comb begin
        st_clr = st_w1c;
        st_clr[ST_HS] = st_w1c[ST_HS] || stop_c;
        if (auto_clr) begin
            st_clr[ST_SEXT] = 1'b1;
            st_clr[ST_LOWT] = 1'b1;
            st_clr[ST_TRANSMIT_CLASH_FLAG] = 1'b1;
            st_clr[ST_BUS_FAULT_FLAG] = 1'b1;
        end
    end

    // Flag set and clear pulses
    always_comb begin
        flg_set = 8'h00;
        flg_set[FLG_DATA_READY_FLAG] = evt.byte_done;
        flg_set[FLG_ADDRESS_MATCH_FLAG] = evt.addr_match;
        flg_set[FLG_STOP_RECEIVED_FLAG] = stop_ours;
        // Any of the four error sources raises the error flag
        flg_set[FLG_ERROR] = evt.ext_tout || evt.low_tout ||
                             evt.tx_clash || st_set[ST_BUS_FAULT_FLAG];
        flg_clr = flg_w1c;
        flg_clr[FLG_DATA_READY_FLAG] = flg_w1c[FLG_DATA_READY_FLAG] || data_wr || smart_rd ||
                            cmd_valid;
        flg_clr[FLG_ADDRESS_MATCH_FLAG] = flg_w1c[FLG_ADDRESS_MATCH_FLAG] || cmd_wr;
        flg_clr[FLG_STOP_RECEIVED_FLAG] = flg_w1c[FLG_STOP_RECEIVED_FLAG] ||
                            (cmd_valid && q_r.flg[FLG_ADDRESS_MATCH_FLAG]);
    end

    // Next-state logic for the whole block
    always_comb begin
        logic [31:0] rv;
        rv = 32'h0;
        q_nxt = q_r;
        // Pulses last one cycle
        q_nxt.ack_go = 1'b0;
        q_nxt.cmd_go = 1'b0;

        // Two-stage synchronisers, then a delayed copy for edges
        q_nxt.scl_s1 = scl_in;
        q_nxt.scl_s2 = q_r.scl_s1;
        q_nxt.scl_d = q_r.scl_s2;
        q_nxt.sda_s1 = sda_in;
        q_nxt.sda_s2 = q_r.sda_s1;
        q_nxt.sda_d = q_r.sda_s2;

        // Start with no clock pulse before a stop is illegal
        if (start_c) begin
            q_nxt.start_seen = 1'b1;
        end else if (scl_fall || stop_c) begin
            q_nxt.start_seen = 1'b0;
        end

        // Transaction tracking for the stop flag; match wins over edges
        if (evt.addr_match) begin
            q_nxt.txn = 1'b1;
            q_nxt.grp = 1'b1;
        end else if (stop_c) begin
            q_nxt.txn = 1'b0;
            q_nxt.grp = 1'b0;
        end else if (start_c) begin
            q_nxt.txn = 1'b0;
        end

        // Write address and data taken in either order
        if (s_axi_awvalid && !q_r.aw_v) begin
            q_nxt.aw_v = 1'b1;
            q_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q_r.w_v) begin
            q_nxt.w_v = 1'b1;
            q_nxt.w_data = s_axi_wdata;
            q_nxt.w_strb = s_axi_wstrb;
        end
        if (do_wr) begin
            q_nxt.aw_v = 1'b0;
            q_nxt.w_v = 1'b0;
            q_nxt.b_v = 1'b1;
            q_nxt.b_resp = (wsel == '0) ? RESP_SLVERR : RESP_OKAY;
        end else if (q_r.b_v && s_axi_bready) begin
            q_nxt.b_v = 1'b0;
        end

        // Enables: set and clear views of one register
        if (do_wr && wsel[SEL_ENCLR]) begin
            q_nxt.en = q_r.en & ~(wd[7:0] & FLG_MASK);
        end
        if (do_wr && wsel[SEL_ENSET]) begin
            q_nxt.en = q_r.en | (wd[7:0] & FLG_MASK);
        end

        // Control fields; only writable bits are stored
        if (do_wr && wsel[SEL_CTRL]) begin
            if (q_r.w_strb[1]) begin
                q_nxt.smart_mode_enable = wd[CB_SMART_MODE_ENABLE];
                q_nxt.group_command_enable = wd[CB_GROUP_COMMAND_ENABLE];
            end
            if (q_r.w_strb[2]) begin
                q_nxt.ack_action = wd[CB_ACKNOWLEDGE_ACTION];
            end
        end
        if (data_wr) begin
            q_nxt.tx_byte = wd[7:0];
        end

        // Hand valid commands to the engine
        if (cmd_valid) begin
            q_nxt.cmd_go = 1'b1;
            q_nxt.cmd_code = wd[CB_CMD+1:CB_CMD];
        end

        // Acknowledge action: 0 acks, 1 nacks; sent on match clear,
        // command three, host-write finish, or smart-mode data read
        if (address_match_flag_sw_clr || cmd3 || smart_rd ||
            (cmd_valid && !q_r.st[ST_DIR])) begin
            q_nxt.ack_go = 1'b1;
            q_nxt.ack_nack = q_r.ack_action;
        end

        // Sticky flags and status: set beats a clear in the same cycle
        q_nxt.flg = (q_r.flg & ~flg_clr) | flg_set;
        q_nxt.st = (q_r.st & ~st_clr) | st_set;
        q_nxt.st[ST_HOLD] = 1'b0;

        // Direction and start kind captured with the address
        if (evt.addr_match) begin
            q_nxt.st[ST_DIR] = evt.addr_dir;
            q_nxt.st[ST_SR] = evt.addr_rep_start;
        end
        if (evt.byte_done) begin
            q_nxt.st[ST_RECEIVED_NOT_ACK] = evt.host_nack;
        end

        // After a clash the lines stay free until we are addressed
        if (evt.tx_clash) begin
            q_nxt.released = 1'b1;
        end else if (evt.addr_match) begin
            q_nxt.released = 1'b0;
        end

        // Read mux; unmapped reads answer zero with slave error
        case (1'b1)
            rsel[SEL_CTRL]: begin
                rv[CB_SMART_MODE_ENABLE] = q_r.smart_mode_enable;
                rv[CB_GROUP_COMMAND_ENABLE] = q_r.group_command_enable;
                rv[CB_ACKNOWLEDGE_ACTION] = q_r.ack_action;
            end
            rsel[SEL_ENCLR], rsel[SEL_ENSET]: begin
                rv[7:0] = q_r.en;
            end
            rsel[SEL_FLAGS]: begin
                rv[7:0] = q_r.flg;
            end
            rsel[SEL_STATUS]: begin
                rv[15:0] = q_r.st;
                // Hold view tracks the two stretching flags
                rv[ST_HOLD] = q_r.flg[FLG_DATA_READY_FLAG] ||
                              q_r.flg[FLG_ADDRESS_MATCH_FLAG];
            end
            rsel[SEL_DATA]: begin
                rv[7:0] = evt.rx_byte;
            end
            default: begin
                rv = 32'h0;
            end
        endcase

        // Read channel: answer one cycle after the address
        if (rd_take) begin
            q_nxt.r_v = 1'b1;
            q_nxt.r_data = rv;
            q_nxt.r_resp = (rsel == '0) ? RESP_SLVERR : RESP_OKAY;
        end else if (q_r.r_v && s_axi_rready) begin
            q_nxt.r_v = 1'b0;
        end
    end

    // State register; synchronous reset to constants only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= '0;
            q_r.en <= ENABLE_RST;
            q_r.flg <= FLAGS_RST;
            q_r.st <= STATUS_RST;
            q_r.scl_s1 <= 1'b1; // Idle bus reads high
            q_r.scl_s2 <= 1'b1;
            q_r.scl_d <= 1'b1;
            q_r.sda_s1 <= 1'b1;
            q_r.sda_s2 <= 1'b1;
            q_r.sda_d <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Port drive
    assign s_axi_awready = !q_r.aw_v;
    assign s_axi_wready = !q_r.w_v;
    assign s_axi_bvalid = q_r.b_v;
    assign s_axi_bresp = q_r.b_resp;
    assign s_axi_arready = !q_r.r_v;
    assign s_axi_rvalid = q_r.r_v;
    assign s_axi_rdata = q_r.r_data;
    assign s_axi_rresp = q_r.r_resp;
    // Stretch while data ready or address match waits for software, unless released
    assign scl_hold_oe = (q_r.flg[FLG_DATA_READY_FLAG] || q_r.flg[FLG_ADDRESS_MATCH_FLAG]) &&
                         !q_r.released;
    assign lines_released = q_r.released;
    assign ack_go = q_r.ack_go;
    assign ack_nack = q_r.ack_nack;
    assign cmd_go = q_r.cmd_go;
    assign cmd_code = q_r.cmd_code;
    assign tx_data = q_r.tx_byte;
    assign irq = |(q_r.flg & q_r.en);

    // Checks next to the logic they guard
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_clr_write(int idx, int bitn);
        do_wr && wsel[idx] && wd[bitn];
    endsequence

    // Time-out standing with no fresh time-out in this cycle
    sequence s_tout_raised;
        q_r.st[ST_LOWT] && !evt.low_tout;
    endsequence

    enable_clear_a: assert property (
        s_clr_write(SEL_ENCLR, FLG_DATA_READY_FLAG) |=> !q_r.en[FLG_DATA_READY_FLAG])
        else $error("enable clear write left enable set");
    enable_set_a: assert property (
        do_wr && wsel[SEL_ENSET] && wd[FLG_ADDRESS_MATCH_FLAG]
        |=> q_r.en[FLG_ADDRESS_MATCH_FLAG])
        else $error("enable set write did not raise enable");
    error_flag_a: assert property (
        evt.low_tout |=> q_r.flg[FLG_ERROR] && q_r.st[ST_LOWT])
        else $error("time-out did not raise error flag");
    data_ready_flag_set_a: assert property (
        evt.byte_done |=> q_r.flg[FLG_DATA_READY_FLAG] ##0 scl_hold_oe != q_r.released)
        else $error("finished byte did not raise data ready");
    data_ready_flag_clear_a: assert property (
        data_wr && !evt.byte_done |=> !q_r.flg[FLG_DATA_READY_FLAG])
        else $error("data write left data ready set");
    match_ack_a: assert property (
        address_match_flag_sw_clr |=> ack_go && ack_nack == $past(q_r.ack_action))
        else $error("match clear sent no acknowledge action");
    stop_flag_a: assert property (
        stop_c && q_r.txn |=> q_r.flg[FLG_STOP_RECEIVED_FLAG])
        else $error("stop of own transaction not flagged");
    hs_stop_a: assert property (
        stop_c && !evt.hs_code |=> !q_r.st[ST_HS])
        else $error("high speed bit survived a stop");
    tout_auto_clear_a: assert property (
        s_tout_raised ##0 cmd3 |=> !q_r.st[ST_LOWT])
        else $error("command three left time-out set");
    irq_level_a: assert property (
        q_r.flg[FLG_ADDRESS_MATCH_FLAG] && q_r.en[FLG_ADDRESS_MATCH_FLAG] |-> irq)
        else $error("enabled flag did not raise interrupt");
    resp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before ready");

endmodule // ics_top

// >>> bench/ics_host_model.sv
// Two-wire bus host model driving clock and data toward the client
`timescale 1ns/1ps
module ics_host_model (
    output logic scl,
    output logic sda
);
    // Idle bus: both lines at the pull-up level, clock stands still
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Start: data falls while clock high; offset keeps pins off aclk edges
    task automatic start_c();
        #3 sda = 1'b0;
        #40;
    endtask
    // Clock bits at 80 ns; data only moves while clock is low
    task automatic bits(input int n);
        #3;
        repeat (n) begin
            scl = 1'b0;
            #20 sda = ~sda;
            #20 scl = 1'b1;
            #40;
        end
        scl = 1'b0;
        #20 sda = 1'b0;
        #20 scl = 1'b1;
        #40;
    endtask
    // Stop: data rises while clock high
    task automatic stop_c();
        sda = 1'b1;
        #40;
    endtask
endmodule // ics_host_model

// >>> bench/tb_top.sv
// Self-checking bench for the client flag, enable and status registers
`timescale 1ns/1ps
module tb_top;
    import ics_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, scl_in, sda_in, scl_hold_oe, lines_released;
    logic ack_go, ack_nack, cmd_go, irq, ack_val;
    logic [1:0] s_axi_bresp, s_axi_rresp, cmd_code, resp;
    logic [31:0] s_axi_rdata, rdv, v, c;
    logic [7:0] tx_data;
    ics_evt_s evt = '0;
    ics_evt_s e;
    int n_errors = 0;
    int n_checks = 0;
    int seed = 97615;
    int n_ack = 0;
    int n_cmd = 0;

    // 100 MHz clock
    always #5 aclk = ~aclk;

    ics_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in, .sda_in,
        .evt, .scl_hold_oe, .lines_released, .ack_go, .ack_nack, .cmd_go,
        .cmd_code, .tx_data, .irq);
    ics_host_model i_host (.scl(scl_in), .sda(sda_in));

    // Count strobes toward the shift engine; they stand one cycle only
    always @(posedge aclk) begin
        if (ack_go === 1'b1) begin
            n_ack <= n_ack + 1;
            ack_val <= ack_nack;
        end
        if (cmd_go === 1'b1) n_cmd <= n_cmd + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Expected enables after a set pattern and a clear pattern
    function automatic logic [31:0] en_exp(input logic [31:0] s, k);
        return s & ~k & 32'(FLG_MASK);
    endfunction

    // Write one word; address and data released each when taken
    // No cycle limit here: only the watchdog ends a hang
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= idx << 2;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Read one word, rready held until the answer
    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= idx << 2;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] i, input logic [31:0] m, x);
        rd(i, rdv);
        chk(rdv & m, x);
    endtask

    // One-cycle engine event, then let it settle; received byte is a level
    task automatic pulse(input ics_evt_s p);
        ics_evt_s q;
        q = '0;
        q.rx_byte = p.rx_byte;
        @(posedge aclk);
        evt <= p;
        @(posedge aclk);
        evt <= q;
        repeat (2) @(posedge aclk);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rc(IDX_ENCLR, 32'hff, 32'(ENABLE_RST));
        rc(IDX_FLAGS, 32'hff, 32'(FLAGS_RST));
        rc(IDX_STATUS, 32'hffff, 32'(STATUS_RST));
        wr(8'h3c, 32'hffffffff);
        chk(32'(resp), 32'(RESP_SLVERR));
        rc(8'h3c, 32'hffffffff, 32'h0);
        chk(32'(resp), 32'(RESP_SLVERR));
        $display("reset test done");
        // Random enable patterns through both views
        repeat (4) begin
            v = $random(seed);
            c = $random(seed);
            wr(IDX_ENCLR, 32'hff);
            wr(IDX_ENSET, v);
            rc(IDX_ENCLR, 32'hff, en_exp(v, 32'h0));
            wr(IDX_ENCLR, c);
            rc(IDX_ENSET, 32'hff, en_exp(v, c));
        end
        wr(IDX_ENSET, 32'h87);
        e = '0;
        e.byte_done = 1'b1;
        e.rx_byte = v[7:0];
        pulse(e);
        rc(IDX_FLAGS, 32'h87, 32'h04);
        rc(IDX_STATUS, 32'h80, 32'h80);
        chk(32'({scl_hold_oe, irq}), 32'h3);
        wr(IDX_DATA, c);
        chk(32'(tx_data), c & 32'hff);
        rc(IDX_FLAGS, 32'h87, 32'h00);
        chk(32'({scl_hold_oe, irq}), 32'h0);
        wr(IDX_CTRL, 32'h100);
        pulse(e);
        rc(IDX_DATA, 32'hff, v & 32'hff);
        rc(IDX_FLAGS, 32'h87, 32'h00);
        $display("data ready test done");
        // Each error source in turn
        for (int k = 0; k < 4; k++) begin
            e = '0;
            e.ext_tout = (k == 0);
            e.low_tout = (k == 1);
            e.tx_clash = (k == 2);
            e.bus_fault = (k == 3);
            pulse(e);
            rc(IDX_FLAGS, 32'h80, 32'h80);
            wr(IDX_FLAGS, 32'h00);
            rc(IDX_FLAGS, 32'h80, 32'h80);
            wr(IDX_FLAGS, 32'h80);
            rc(IDX_FLAGS, 32'h80, 32'h00);
        end
        rc(IDX_STATUS, 32'h643, 32'h243);
        chk(32'(lines_released), 32'h1);
        wr(IDX_STATUS, 32'h200);
        rc(IDX_STATUS, 32'h643, 32'h043);
        // Software clears the match flag under both acknowledge settings
        for (int a = 0; a < 2; a++) begin
            wr(IDX_CTRL, 32'(a) << 18);
            e = '0;
            e.addr_match = 1'b1;
            pulse(e);
            rc(IDX_FLAGS, 32'h02, 32'h02);
            c = n_ack;
            wr(IDX_FLAGS, 32'h02);
            repeat (2) @(posedge aclk);
            chk(32'(n_ack) - c, 32'h1);
            chk(32'(ack_val), 32'(a));
            rc(IDX_STATUS, 32'h643, 32'h0);
        end
        chk(32'(lines_released), 32'h0);
        $display("error test done");
        // Addressed frame on the pins, then a command
        e = '0;
        e.hs_code = 1'b1;
        pulse(e);
        rc(IDX_STATUS, 32'h400, 32'h400);
        i_host.start_c();
        e = '0;
        e.addr_match = 1'b1;
        pulse(e);
        i_host.bits(8);
        i_host.stop_c();
        repeat (4) @(posedge aclk);
        rc(IDX_STATUS, 32'h400, 32'h0);
        rc(IDX_FLAGS, 32'h03, 32'h03);
        e = '0;
        e.low_tout = 1'b1;
        pulse(e);
        c = n_cmd;
        wr(IDX_CTRL, 32'h3 << 16);
        rc(IDX_STATUS, 32'h40, 32'h0);
        repeat (2) @(posedge aclk);
        chk(32'(n_cmd) - c, 32'h1);
        chk(32'(cmd_code), 32'(CMD_ACK));
        rc(IDX_FLAGS, 32'h03, 32'h0);
        // Start straight into stop is illegal
        i_host.start_c();
        i_host.stop_c();
        repeat (4) @(posedge aclk);
        rc(IDX_STATUS, 32'h01, 32'h01);
        rc(IDX_FLAGS, 32'h80, 32'h80);
        // Stop of a frame to another client, group command off then on
        for (int g = 0; g < 2; g++) begin
            wr(IDX_CTRL, 32'(g) << 9);
            e = '0;
            e.addr_match = 1'b1;
            pulse(e);
            wr(IDX_FLAGS, 32'h03);
            i_host.start_c();
            i_host.bits(8);
            i_host.stop_c();
            repeat (4) @(posedge aclk);
            rc(IDX_FLAGS, 32'h01, 32'(g));
        end
        $display("pin test done");
        wrap_up();
    end
endmodule // tb_top
